// file: hdl/data_fifo.sv
// Flip-flop FIFO with a registered output stage
`timescale 1ns/1ps
module data_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input wire logic clock, // System clock
   input wire logic rst, // Synchronous reset, active high
   fifo_if.buffer port // Fill and drain sides
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
   localparam logic [PW-1:0] LAST_IDX = PW'(DEPTH - 1);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [PW-1:0] wr_reg;
   logic [PW-1:0] rd_reg;
   logic [CW-1:0] count_reg;
   logic out_valid_reg;
   logic [WIDTH-1:0] out_data_reg;
   logic push;
   logic pop;

   // Handshakes on both sides; pop moves a word to the output stage
   assign port.in_ready = (count_reg != FULL_CNT);
   assign push = port.in_valid && port.in_ready;
   assign pop = (count_reg != '0) && (!out_valid_reg || port.out_ready);
   assign port.out_valid = out_valid_reg;
   assign port.out_data = out_data_reg;

   // Storage write
   always_ff @(posedge clock) begin
      if (push) begin
         mem_reg[wr_reg] <= port.in_data;
      end
   end

   // Pointers and occupancy
   always_ff @(posedge clock) begin
      if (rst) begin
         wr_reg <= '0;
         rd_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) begin
            wr_reg <= (wr_reg == LAST_IDX) ? '0 : wr_reg + 1'b1;
         end
         if (pop) begin
            rd_reg <= (rd_reg == LAST_IDX) ? '0 : rd_reg + 1'b1;
         end
         if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
         end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end

   // Output stage
   always_ff @(posedge clock) begin
      if (rst) begin
         out_valid_reg <= 1'b0;
         out_data_reg <= '0;
      end else if (pop) begin
         out_valid_reg <= 1'b1;
         out_data_reg <= mem_reg[rd_reg];
      end else if (port.out_ready) begin
         out_valid_reg <= 1'b0;
      end
   end
endmodule

// file: hdl/fifo_if.sv
// Valid/ready carrier between the sequencer and the data buffer
`timescale 1ns/1ps
interface fifo_if #(parameter int WIDTH = 8);
   logic in_valid;
   logic in_ready;
   logic [WIDTH-1:0] in_data;
   logic out_valid;
   logic out_ready;
   logic [WIDTH-1:0] out_data;
   modport buffer (input in_valid, input in_data, input out_ready,
      output in_ready, output out_valid, output out_data);
   modport user (output in_valid, output in_data, output out_ready,
      input in_ready, input out_valid, input out_data);
endinterface

// file: hdl/nand_host.sv
// Host sequencer for reset, status and parameter page reads
`timescale 1ns/1ps
// Behaviour
// - Reset is command code FFh
// - Change-column allowed during parameter page read
// - After status poll, send 00h before data
// - Never send enhanced status during page read
// - Sizes are in bytes; host converts
// - Command 70h enters status read mode
module nand_host
   import nand_host_pkg::*;
#(
   parameter int DEPTH = 32
) (
   input wire logic clock, // 40 MHz system clock
   input wire logic rst, // Synchronous reset, active high
   input wire logic cmd_valid, // Operation request
   input wire nand_host_pkg::op_t cmd_op, // Requested operation
   input wire logic [15:0] cmd_col, // Column for change-column
   input wire logic [nand_host_pkg::LEN_W-1:0] cmd_len, // Bytes to read
   output logic cmd_ready, // Idle, request taken
   output logic [7:0] status_byte, // Last status read
   output logic status_valid, // Pulse with new status
   output logic pp_active, // Parameter page read open
   output logic out_valid, // Page byte available
   output logic [7:0] out_data, // Page byte
   input wire logic out_ready, // Consumer takes byte
   output logic ce_n, // Chip enable, active low
   output logic cle, // Command latch enable
   output logic ale, // Address latch enable
   output logic we_n, // Write strobe, active low
   output logic re_n, // Read strobe, active low
   output logic wp_n, // Write protect, active low
   output logic [7:0] io_out, // Bus drive value
   output logic io_oe, // Bus driven when high
   input wire logic [7:0] io_in, // Bus sampled value
   input wire logic ready_busy_n // Device ready, low while busy
);
   import nand_host_pkg::*;

   localparam int DW = $clog2(PHASE_CYC + 1);
   localparam logic [DW-1:0] DIV_LAST = DW'(PHASE_CYC - 1);
   localparam int WW = $clog2(WB_CYC + 1);
   localparam logic [WW-1:0] WB_LAST = WW'(WB_CYC - 1);

   state_t state_reg;
   op_t op_reg;
   logic [DW-1:0] div_reg;
   logic tick;
   logic [WW-1:0] wb_reg;
   logic ph_reg;
   logic [1:0] idx_reg;
   logic [2:0] seq_n_reg;
   logic [7:0] seq_byte_reg [SEQ_MAX];
   logic [SEQ_MAX-1:0] seq_ale_reg;
   logic wait_busy_reg;
   logic [LEN_W-1:0] left_reg;
   logic need_resume_reg;
   logic push_reg;
   logic [7:0] push_data_reg;
   logic cmd_ready_reg;
   logic status_valid_reg;
   logic [7:0] status_reg;
   logic pp_active_reg;
   logic accept;
   logic legal;

   fifo_if #(.WIDTH(8)) fif ();

   data_fifo #(.WIDTH(8), .DEPTH(DEPTH)) data_fifo_inst (
      .clock(clock),
      .rst(rst),
      .port(fif.buffer)
   );

   // Page bytes enter the buffer in bus order, low byte first
   assign fif.in_valid = push_reg;
   assign fif.in_data = push_data_reg;
   assign fif.out_ready = out_ready;
   assign out_valid = fif.out_valid;
   assign out_data = fif.out_data;
   assign cmd_ready = cmd_ready_reg;
   assign status_byte = status_reg;
   assign status_valid = status_valid_reg;
   assign pp_active = pp_active_reg;

   // Write protect held released from a flop so status resets to E0h
   always_ff @(posedge clock) begin
      wp_n <= 1'b1;
   end

   // Column ops and reads only make sense inside a page read
   assign legal = ((cmd_op != OP_COLUMN) && (cmd_op != OP_READ))
      || pp_active_reg;
   assign accept = cmd_valid && cmd_ready_reg;

   // Bus phase divider, one-cycle enable
   always_ff @(posedge clock) begin
      if (rst || state_reg == ST_IDLE) begin
         div_reg <= '0;
      end else begin
         div_reg <= (div_reg == DIV_LAST) ? '0 : div_reg + 1'b1;
      end
   end
   assign tick = (div_reg == DIV_LAST);

   // Page-read session and resume tracking
   always_ff @(posedge clock) begin
      if (rst) begin
         pp_active_reg <= 1'b0;
         need_resume_reg <= 1'b0;
      end else if (accept && legal) begin
         if (cmd_op == OP_RESET) begin
            pp_active_reg <= 1'b0;
            need_resume_reg <= 1'b0;
         end else if (cmd_op == OP_PARAM) begin
            pp_active_reg <= 1'b1;
            need_resume_reg <= 1'b0;
         end else if (cmd_op == OP_STATUS) begin
            need_resume_reg <= pp_active_reg;
         end else begin
            need_resume_reg <= 1'b0;
         end
      end
   end

   // Main sequencer: command/address cycles, busy wait, read cycles
   always_ff @(posedge clock) begin
      if (rst) begin
         state_reg <= ST_IDLE;
         op_reg <= OP_RESET;
         cmd_ready_reg <= 1'b1;
         ph_reg <= 1'b0;
         idx_reg <= '0;
         seq_n_reg <= '0;
         seq_ale_reg <= '0;
         for (int i = 0; i < SEQ_MAX; i++) begin
            seq_byte_reg[i] <= IDLE_BYTE;
         end
         wait_busy_reg <= 1'b0;
         left_reg <= '0;
         wb_reg <= '0;
         ce_n <= 1'b1;
         cle <= 1'b0;
         ale <= 1'b0;
         we_n <= 1'b1;
         re_n <= 1'b1;
         io_out <= IDLE_BYTE;
         io_oe <= 1'b0;
         push_reg <= 1'b0;
         push_data_reg <= IDLE_BYTE;
         status_valid_reg <= 1'b0;
         status_reg <= IDLE_BYTE;
      end else begin
         push_reg <= 1'b0;
         status_valid_reg <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               if (accept && legal) begin
                  op_reg <= cmd_op;
                  cmd_ready_reg <= 1'b0;
                  ce_n <= 1'b0;
                  ph_reg <= 1'b0;
                  idx_reg <= '0;
                  seq_ale_reg <= '0;
                  wait_busy_reg <= 1'b0;
                  left_reg <= cmd_len;
                  state_reg <= ST_SEND;
                  case (cmd_op)
                     OP_RESET: begin
                        seq_byte_reg[0] <= CMD_RESET;
                        seq_n_reg <= 3'd1;
                        wait_busy_reg <= 1'b1;
                        left_reg <= '0;
                     end
                     OP_STATUS: begin
                        seq_byte_reg[0] <= CMD_STATUS;
                        seq_n_reg <= 3'd1;
                        left_reg <= LEN_W'(1);
                     end
                     OP_PARAM: begin
                        seq_byte_reg[0] <= CMD_PARAM;
                        seq_byte_reg[1] <= PARAM_ADDR;
                        seq_ale_reg <= 4'b0010;
                        seq_n_reg <= 3'd2;
                        wait_busy_reg <= 1'b1;
                     end
                     OP_COLUMN: begin
                        seq_byte_reg[0] <= CMD_CHG_COL;
                        seq_byte_reg[1] <= cmd_col[7:0];
                        seq_byte_reg[2] <= cmd_col[15:8];
                        seq_byte_reg[3] <= CMD_CHG_COL_GO;
                        seq_ale_reg <= 4'b0110;
                        seq_n_reg <= 3'd4;
                     end
                     default: begin
                        // Resume with 00h only after a status poll
                        seq_byte_reg[0] <= CMD_READ;
                        seq_n_reg <= need_resume_reg ? 3'd1 : 3'd0;
                        if (!need_resume_reg) begin
                           state_reg <= ST_READ;
                        end
                     end
                  endcase
               end else if (accept) begin
                  cmd_ready_reg <= 1'b1;
               end
            end
            ST_SEND: begin
               if (tick && !ph_reg) begin
                  cle <= !seq_ale_reg[idx_reg];
                  ale <= seq_ale_reg[idx_reg];
                  io_out <= seq_byte_reg[idx_reg];
                  io_oe <= 1'b1;
                  we_n <= 1'b0;
                  ph_reg <= 1'b1;
               end else if (tick) begin
                  we_n <= 1'b1;
                  ph_reg <= 1'b0;
                  if ({1'b0, idx_reg} + 3'd1 == seq_n_reg) begin
                     wb_reg <= '0;
                     if (wait_busy_reg) begin
                        state_reg <= ST_WAIT_WB;
                     end else if (left_reg != '0) begin
                        state_reg <= ST_READ;
                     end else begin
                        state_reg <= ST_IDLE;
                        cmd_ready_reg <= 1'b1;
                     end
                  end else begin
                     idx_reg <= idx_reg + 1'b1;
                  end
               end
            end
            ST_WAIT_WB: begin
               // Let the device pull the busy line low first
               cle <= 1'b0;
               ale <= 1'b0;
               io_oe <= 1'b0;
               wb_reg <= wb_reg + 1'b1;
               if (wb_reg == WB_LAST) begin
                  state_reg <= ST_WAIT_RDY;
               end
            end
            ST_WAIT_RDY: begin
               if (ready_busy_n) begin
                  if (left_reg != '0) begin
                     state_reg <= ST_READ;
                  end else begin
                     state_reg <= ST_IDLE;
                     ce_n <= 1'b1;
                     cmd_ready_reg <= 1'b1;
                  end
               end
            end
            ST_READ: begin
               cle <= 1'b0;
               ale <= 1'b0;
               io_oe <= 1'b0;
               if (tick && !ph_reg) begin
                  // Buffer room stalls the strobe, never drops a byte
                  if (op_reg == OP_STATUS || fif.in_ready) begin
                     re_n <= 1'b0;
                     ph_reg <= 1'b1;
                  end
               end else if (tick) begin
                  re_n <= 1'b1;
                  ph_reg <= 1'b0;
                  left_reg <= left_reg - 1'b1;
                  if (op_reg == OP_STATUS) begin
                     status_reg <= io_in;
                     status_valid_reg <= 1'b1;
                  end else begin
                     push_reg <= 1'b1;
                     push_data_reg <= io_in;
                  end
                  if (left_reg == LEN_W'(1)) begin
                     state_reg <= ST_IDLE;
                     cmd_ready_reg <= 1'b1;
                     ce_n <= !pp_active_reg;
                  end
               end
            end
            default: begin
               state_reg <= ST_IDLE;
               cmd_ready_reg <= 1'b1;
            end
         endcase
      end
   end

   // Checks on the bus the controller drives and on the bytes it captures
   reset_code_a: assert property (@(posedge clock) disable iff (rst)
      (op_reg == OP_RESET && state_reg == ST_SEND && !we_n && cle)
      |-> io_out == CMD_RESET)
      else $error("reset command byte is not FFh");
   column_in_page_a: assert property (@(posedge clock) disable iff (rst)
      (!we_n && cle && io_out == CMD_CHG_COL) |-> pp_active_reg)
      else $error("change column issued outside page read");
   resume_first_a: assert property (@(posedge clock) disable iff (rst)
      $fell(re_n) && op_reg != OP_STATUS |-> !need_resume_reg)
      else $error("page data read without 00h after status");
   no_enh_status_a: assert property (@(posedge clock) disable iff (rst)
      (!we_n && cle) |-> io_out != CMD_STATUS_ENH)
      else $error("enhanced status command issued");
   byte_count_a: assert property (@(posedge clock) disable iff (rst)
      push_reg |-> $past(left_reg, 1) != '0)
      else $error("more bytes pushed than requested");
   status_load_a: assert property (@(posedge clock) disable iff (rst)
      status_valid_reg |-> op_reg == OP_STATUS && $past(re_n, 1) == 1'b0)
      else $error("status captured outside status read");
   param_addr_a: assert property (@(posedge clock) disable iff (rst)
      (op_reg == OP_PARAM && !we_n && ale) |-> io_out == PARAM_ADDR)
      else $error("parameter page address is not 00h");
   read_after_ready_a: assert property (@(posedge clock) disable iff (rst)
      (state_reg == ST_WAIT_RDY && !ready_busy_n) |=> re_n && we_n)
      else $error("strobe while device busy");

   reset_done_c: cover property (@(posedge clock) disable iff (rst)
      op_reg == OP_RESET && state_reg == ST_WAIT_RDY ##1 cmd_ready_reg);
   page_byte_c: cover property (@(posedge clock) disable iff (rst)
      op_reg == OP_PARAM && push_reg);
   resume_c: cover property (@(posedge clock) disable iff (rst)
      op_reg == OP_READ && state_reg == ST_SEND && !we_n);
endmodule

// file: hdl/nand_host_pkg.sv
// Shared constants and types for the flash host controller
package nand_host_pkg;
   // Command codes for command latch cycles, the page address byte and the idle bus value
   localparam logic [7:0] CMD_RESET = 8'hFF;
   localparam logic [7:0] CMD_STATUS = 8'h70;
   localparam logic [7:0] CMD_STATUS_ENH = 8'h78;
   localparam logic [7:0] CMD_READ = 8'h00;
   localparam logic [7:0] CMD_PARAM = 8'hEC;
   localparam logic [7:0] CMD_CHG_COL = 8'h05;
   localparam logic [7:0] CMD_CHG_COL_GO = 8'hE0;
   localparam logic [7:0] PARAM_ADDR = 8'h00;
   localparam logic [7:0] IDLE_BYTE = 8'h00;
   // Timing, nanoseconds as printed, cycles derived
   localparam int CLK_NS = 25;
   localparam int PHASE_NS = 50;
   localparam int WB_NS = 100;
   // Least time rounded up to whole cycles, never below one
   function automatic int ceil_cyc(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction
   localparam int PHASE_CYC = ceil_cyc(PHASE_NS);
   localparam int WB_CYC = ceil_cyc(WB_NS);
   // Sequencer sizing
   localparam int SEQ_MAX = 4;
   localparam int LEN_W = 10;
   localparam int PAGE_COPY_BYTES = 256;
   // User operations
   typedef enum logic [2:0] {
      OP_RESET = 3'b000,
      OP_STATUS = 3'b001,
      OP_PARAM = 3'b010,
      OP_COLUMN = 3'b011,
      OP_READ = 3'b100
   } op_t;
   // Bus sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SEND = 3'b001,
      ST_WAIT_WB = 3'b010,
      ST_WAIT_RDY = 3'b011,
      ST_READ = 3'b100
   } state_t;
endpackage

// file: tb/flash_model.sv
// Behavioural flash device answering the host sequencer's bus cycles
`timescale 1ns/1ps
module flash_model #(
   parameter int T_RST_NS = 2000, // Busy time after reset
   parameter int T_R_NS = 1000 // Busy time to load the parameter page
) (
   input wire logic ce_n, // Chip enable, active low
   input wire logic cle, // Command latch enable
   input wire logic ale, // Address latch enable
   input wire logic we_n, // Write strobe, active low
   input wire logic re_n, // Read strobe, active low
   input wire logic [7:0] io_bus, // Resolved bus level
   output logic [7:0] io_drv, // Device drive value
   output logic ready_busy_n // Low while busy
);
   logic [7:0] status_reg = 8'hE0;
   logic status_mode = 1'b0;
   logic [15:0] col = 16'h0000;
   logic [7:0] last_cmd = 8'h00;
   int addr_cnt = 0;
   initial ready_busy_n = 1'b1;
   initial io_drv = 8'h5A;
   // Fixed page image, repeated every 256 bytes, low byte first
   function automatic logic [7:0] page(input logic [15:0] i);
      case (i[7:0])
         8'd0: return 8'h4F;
         8'd1: return 8'h4E;
         8'd2: return 8'h46;
         8'd3: return 8'h49;
         8'd4: return 8'h02;
         8'd6: return 8'h1C;
         8'd8: return 8'h3B;
         8'd81: return 8'h08;
         8'd84: return 8'h40;
         8'd92: return 8'h40;
         8'd101: return 8'h22;
         8'd111: return 8'h11;
         8'd114: return 8'h03;
         8'd129: return 8'h1F;
         default: return 8'h00;
      endcase
   endfunction
   // Command and address latch; the process sleeps while busy
   always @(posedge we_n) begin
      if (!ce_n && cle) begin
         last_cmd = io_bus;
         addr_cnt = 0;
         case (io_bus)
            8'hFF: begin
               status_reg = 8'hE0;
               status_mode = 1'b0;
               ready_busy_n = 1'b0;
               #(T_RST_NS) ready_busy_n = 1'b1;
            end
            8'h70: status_mode = 1'b1;
            8'h00, 8'hE0: status_mode = 1'b0;
            default: ;
         endcase
      end else if (!ce_n && ale && last_cmd == 8'hEC) begin
         col = 16'h0000;
         status_mode = 1'b0;
         ready_busy_n = 1'b0;
         #(T_R_NS) ready_busy_n = 1'b1;
      end else if (!ce_n && ale && last_cmd == 8'h05) begin
         if (addr_cnt == 0)
            col[7:0] = io_bus;
         else
            col[15:8] = io_bus;
         addr_cnt++;
      end
   end
   // Output a byte on each falling read strobe
   always @(negedge re_n) begin
      if (status_mode) begin
         io_drv = status_reg;
      end else begin
         io_drv = page(col);
         col = col + 16'h0001;
      end
   end
   // Data hold expires shortly after the strobe rises
   always @(posedge re_n) io_drv = #5 ~io_drv;
endmodule

// file: tb/nand_reset_param_page_test.sv
// Self-checking bench for the flash host sequencer
`timescale 1ns/1ps
module nand_reset_param_page_test;
   import nand_host_pkg::*;
   localparam int LIMIT = 60000;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic cmd_valid = 1'b0;
   op_t cmd_op = OP_STATUS;
   logic [15:0] cmd_col = 16'h0000;
   logic [LEN_W-1:0] cmd_len = 10'h000;
   logic out_ready = 1'b0;
   logic cmd_ready, status_valid, pp_active, out_valid;
   logic ce_n, cle, ale, we_n, re_n, wp_n, io_oe, ready_busy_n;
   logic [7:0] status_byte, out_data, io_out, io_drv, last_cmd;
   wire logic [7:0] io_in;
   logic stall = 1'b1;
   logic [7:0] got[$];
   int failures = 0;
   int compares = 0;
   int cycles = 0;
   int pulses = 0;
   int corner[3] = '{0, 255, 767};
   assign io_in = io_oe ? io_out : io_drv;
   always #12.5 clock = ~clock;
   nand_host #(.DEPTH(32)) nand_host_inst (.clock(clock), .rst(rst),
      .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_col(cmd_col),
      .cmd_len(cmd_len), .cmd_ready(cmd_ready), .status_byte(status_byte),
      .status_valid(status_valid), .pp_active(pp_active),
      .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready),
      .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n),
      .wp_n(wp_n), .io_out(io_out), .io_oe(io_oe), .io_in(io_in),
      .ready_busy_n(ready_busy_n));
   flash_model flash_model_inst (.ce_n(ce_n), .cle(cle), .ale(ale),
      .we_n(we_n), .re_n(re_n), .io_bus(io_in), .io_drv(io_drv),
      .ready_busy_n(ready_busy_n));
   task automatic end_sim();
      if (failures == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Expected page byte for a position counted from the first copy
   function automatic logic [7:0] exp_byte(input int i);
      case (i % 256)
         0: return 8'h4F;
         1: return 8'h4E;
         2: return 8'h46;
         3: return 8'h49;
         4: return 8'h02;
         6: return 8'h1C;
         8: return 8'h3B;
         81: return 8'h08;
         84: return 8'h40;
         92: return 8'h40;
         101: return 8'h22;
         111: return 8'h11;
         114: return 8'h03;
         129: return 8'h1F;
         default: return 8'h00;
      endcase
   endfunction
   // Cycle limit, random drain, byte collector, status pulse count
   always @(posedge clock) begin
      cycles++;
      out_ready <= !stall && ($urandom % 4 != 0);
      if (out_valid && out_ready)
         got.push_back(out_data);
      if (status_valid === 1'b1)
         pulses++;
      if (cycles == LIMIT) begin
         failures++;
         end_sim();
      end
   end
   // Watch command bytes that the host latches
   always @(posedge we_n) begin
      if (cle) begin
         last_cmd = io_out;
         if (pp_active) check(16'(io_out == CMD_STATUS_ENH), 16'h0000);
      end
   end
   // Issue one operation and wait until the sequencer is idle again
   task automatic do_op(input op_t op, input int col, input int len,
         output int took);
      took = 0;
      @(posedge clock);
      cmd_valid <= 1'b1;
      cmd_op <= op;
      cmd_col <= col[15:0];
      cmd_len <= len[LEN_W-1:0];
      @(posedge clock);
      cmd_valid <= 1'b0;
      do begin
         @(posedge clock);
         #1;
         took++;
      end while (cmd_ready !== 1'b1);
   endtask
   // Compare collected bytes with the page image from a start position
   task automatic expect_run(input int start, input int n);
      int w;
      w = 0;
      while (got.size() < n && w < 3000) begin
         @(posedge clock);
         w++;
      end
      check(16'(got.size()), 16'(n));
      for (int i = 0; i < n && i < got.size(); i++)
         check(got[i], exp_byte(start + i));
      got.delete();
   endtask
   initial begin
      int t;
      int col;
      int len;
      void'($urandom(32'h2d9e_27cd));
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      #1;
      check({cmd_ready, ce_n, io_oe, pp_active, out_valid, wp_n, cle, ale,
         we_n, re_n}, 10'b11_0001_0011);
      // Two resets in a row, then status
      for (int k = 0; k < 2; k++) begin
         do_op(OP_RESET, 0, 0, t);
         check(last_cmd, 8'hFF);
         check(16'(t >= 80), 16'h0001);
         check(ce_n, 1'b1);
      end
      do_op(OP_STATUS, 0, 0, t);
      // Let the pulse counter see the status strobe before comparing
      @(posedge clock);
      #1;
      check(status_byte, 8'hE0);
      check(16'(pulses), 16'h0001);
      // Parameter page read with the buffer filled to refusal first
      fork
         do_op(OP_PARAM, 0, 520, t);
         begin
            repeat (400) @(posedge clock);
            #1;
            check({out_valid, re_n, pp_active}, 3'b111);
            check(16'(got.size()), 16'h0000);
            stall <= 1'b0;
         end
      join
      expect_run(0, 520);
      // Status poll inside the session, then resume data output
      do_op(OP_STATUS, 0, 0, t);
      check(status_byte, 8'hE0);
      do_op(OP_READ, 0, 8, t);
      check(last_cmd, CMD_READ);
      expect_run(520, 8);
      // Column changes at corners and random places
      for (int k = 0; k < 6; k++) begin
         col = (k < 3) ? corner[k] : int'($urandom % 768);
         len = 1 + int'($urandom % 60);
         do_op(OP_COLUMN, col, len, t);
         expect_run(col, len);
      end
      // Reset closes the session; a later read is dropped
      do_op(OP_RESET, 0, 0, t);
      check(pp_active, 1'b0);
      do_op(OP_READ, 0, 5, t);
      repeat (50) @(posedge clock);
      check(16'(got.size()), 16'h0000);
      end_sim();
   end
endmodule
